//--- rtl/flash_led_params.svh
`ifndef FLASH_LED_PARAMS_SVH
`define FLASH_LED_PARAMS_SVH
// ==========================================================
// Register map
`define REG_CAL_CFG_ADDR 8'h05
`define REG_THERM_VOUT_ADDR 8'h06
`define CAL_CFG_RESET 8'h6a
`define THERM_VOUT_RESET 8'h09
// ==========================================================
// Field positions
`define BIT_CAL 7
`define BIT_PSM 6
`define BIT_DIR 5
`define BIT_GPIO 4
`define BIT_TYPE 3
`define BIT_TMON 7
`define BIT_HOT 6
`define BIT_WARN 5
`define BIT_HDR 4
`define OV_MSB 3
// ==========================================================
// Analog figures, in mV, for reference by users of the codes
`define HOT_THRESH_MV 345
`define WARN_THRESH_MV 1050
`define OV_BASE_MV 3825
`define OV_STEP_MV 125
// ==========================================================
// Timing
`define CLK_PERIOD_NS 25
`define CAL_SETTLE_NS 10000
`define CAL_SETTLE_CYC ((`CAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CODE_MAX 4'hf
`endif

//--- rtl/flash_led_pkg.sv
`default_nettype none
package flash_led_pkg;
  // Register request from the serial slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;
  // Same bit order as the calibration/config register
  typedef struct packed {
    logic cal_en;
    logic psm;
    logic dir;
    logic gpio_val;
    logic pin_type;
    logic [2:0] led_en;
  } cal_cfg_t;
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK} i2c_state_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_CHECK} cal_state_t;
endpackage : flash_led_pkg
`default_nettype wire

//--- rtl/i2c_reg_slave.sv
`default_nettype none
module i2c_reg_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h5a // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rd_data_in,
  output flash_led_pkg::reg_req_t req_out,
  output logic sda_oe_out
);
  import flash_led_pkg::*;

  logic scl_q_r;
  logic sda_q_r;
  i2c_state_t st_r;
  logic [1:0] phase_r;
  logic rw_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic [7:0] tx_r;

  // ==========================================================
  // Bus conditions
  wire scl_rise = scl_in & ~scl_q_r;
  wire scl_fall = ~scl_in & scl_q_r;
  wire start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
  wire addr_hit = sh_r[7:1] == DEV_ADDR;
  wire byte_done = cnt_r == 4'h8;

  // ==========================================================
  // Transfer engine: device address, sub-address, data bytes
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= I2C_IDLE;
      phase_r <= 2'h0;
      rw_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      req_out <= '0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      // Address follows the pointer so read data is ready before the load
      req_out.wr <= 1'b0;
      req_out.rd <= 1'b0;
      req_out.addr <= ptr_r;
      if (start_det) begin
        st_r <= I2C_RX;
        phase_r <= 2'h0;
        cnt_r <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_det) begin
        st_r <= I2C_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        cnt_r <= cnt_r + 4'h1;
        if (st_r == I2C_RX) begin
          sh_r <= {sh_r[6:0], sda_in};
        end
        if (st_r == I2C_TXACK && sda_in) begin
          st_r <= I2C_IDLE;
        end
      end else if (scl_fall) begin
        unique case (st_r)
          I2C_RX: begin
            if (byte_done && phase_r == 2'h0 && !addr_hit) begin
              st_r <= I2C_IDLE;
            end else if (byte_done) begin
              st_r <= I2C_ACK;
              sda_oe_out <= 1'b1;
              cnt_r <= 4'h0;
              if (phase_r == 2'h0) begin
                rw_r <= sh_r[0];
              end
              if (phase_r == 2'h1) begin
                ptr_r <= sh_r;
              end
              if (phase_r == 2'h2) begin
                req_out.wr <= 1'b1;
                req_out.addr <= ptr_r;
                req_out.data <= sh_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          I2C_ACK: begin
            if (phase_r == 2'h0 && rw_r) begin
              st_r <= I2C_TX;
              cnt_r <= 4'h0;
              tx_r <= rd_data_in;
              sda_oe_out <= ~rd_data_in[7];
              req_out.rd <= 1'b1;
              req_out.addr <= ptr_r;
            end else begin
              st_r <= I2C_RX;
              sda_oe_out <= 1'b0;
              cnt_r <= 4'h0;
              if (phase_r != 2'h2) begin
                phase_r <= phase_r + 2'h1;
              end
            end
          end
          I2C_TX: begin
            if (byte_done) begin
              st_r <= I2C_TXACK;
              sda_oe_out <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_out <= ~tx_r[6];
            end
          end
          I2C_TXACK: begin
            st_r <= I2C_TX;
            cnt_r <= 4'h0;
            tx_r <= rd_data_in;
            sda_oe_out <= ~rd_data_in[7];
            req_out.rd <= 1'b1;
            req_out.addr <= ptr_r;
          end
          I2C_IDLE: begin
          end
          default: begin
            st_r <= I2C_IDLE;
          end
        endcase
      end
    end
  end
endmodule : i2c_reg_slave
`default_nettype wire

//--- rtl/flash_led_config_status_regs.sv
`include "flash_led_params.svh"
`default_nettype none
module flash_led_config_status_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h5a // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic second_strobe_input_in,
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe_out,
  input wire logic temp_hot_cmp_in,
  input wire logic temp_warn_cmp_in,
  input wire logic cal_compare_in,
  input wire logic headroom_ok_in,
  input wire logic flash_end_in,
  output logic power_save_enable_out,
  output logic channel_one_enable_out,
  output logic channel_two_enable_out,
  output logic channel_three_enable_out,
  output logic temp_monitor_enable_out,
  output logic excess_temp_flag_out,
  output logic cal_active_out,
  output logic [3:0] output_voltage_code_out
);
  import flash_led_pkg::*;

  localparam int NSYNC = 8;
  localparam logic [NSYNC-1:0] SYNC_RST = 8'h03; // Serial lines idle high
  localparam logic [7:0] CFG_RST = `CAL_CFG_RESET;
  localparam logic [7:0] THERM_RST = `THERM_VOUT_RESET;
  localparam logic [8:0] SETTLE_LAST = 9'(`CAL_SETTLE_CYC - 1);

  // ==========================================================
  // Input synchronisers
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  assign raw_in = {headroom_ok_in, cal_compare_in, temp_warn_cmp_in, temp_hot_cmp_in,
                   gpio_in, second_strobe_input_in, sda_in, scl_in};
  generate
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          meta_r[g] <= SYNC_RST[g];
          sync_r[g] <= SYNC_RST[g];
        end else begin
          meta_r[g] <= raw_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate
  wire scl_s = sync_r[0];
  wire sda_s = sync_r[1];
  wire strobe_s = sync_r[2];
  wire gpio_s = sync_r[3];
  wire hot_s = sync_r[4];
  wire warn_s = sync_r[5];
  wire cal_cmp_s = sync_r[6];
  wire hdr_ok_s = sync_r[7];

  // ==========================================================
  // Serial slave
  reg_req_t req;
  logic [7:0] rd_data;
  i2c_reg_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .rd_data_in(rd_data),
    .req_out(req),
    .sda_oe_out(sda_oe_out)
  );
  assign sda_out = 1'b0;

  // ==========================================================
  // Register state
  cal_cfg_t cfg_r;
  cal_cfg_t cfg_nxt;
  logic tmon_r;
  logic hot_r;
  logic hot_nxt;
  logic warn_r;
  logic warn_nxt;
  logic hdr_r;
  logic hdr_nxt;
  logic [3:0] ov_target_r;
  logic [3:0] cal_result_r;
  logic cal_done_r;
  logic [3:0] cal_code_r;
  logic [8:0] cal_cnt_r;
  cal_state_t cal_st_r;

  // ==========================================================
  // Decode
  wire wr_cfg = req.wr && req.addr == `REG_CAL_CFG_ADDR;
  wire wr_therm = req.wr && req.addr == `REG_THERM_VOUT_ADDR;
  wire rd_therm = req.rd && req.addr == `REG_THERM_VOUT_ADDR;
  wire cal_start = wr_cfg && req.data[`BIT_CAL];
  wire cal_abort = wr_cfg && !req.data[`BIT_CAL];
  wire hot_clear = wr_therm && !req.data[`BIT_HOT];
  wire hot_set = tmon_r && hot_s;
  wire warn_set = tmon_r && warn_s;

  // ==========================================================
  // Next values; hardware set wins over clear
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = cal_cfg_t'(req.data);
    end else if (!cfg_r.dir) begin
      cfg_nxt.gpio_val = gpio_s;
    end
  end
  assign hot_nxt = hot_set | (hot_r & ~hot_clear);
  assign warn_nxt = warn_set | (warn_r & ~rd_therm);
  assign hdr_nxt = flash_end_in ? hdr_ok_s : hdr_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_r <= cal_cfg_t'(CFG_RST);
      tmon_r <= THERM_RST[`BIT_TMON];
      hot_r <= THERM_RST[`BIT_HOT];
      warn_r <= THERM_RST[`BIT_WARN];
      hdr_r <= THERM_RST[`BIT_HDR];
      ov_target_r <= THERM_RST[`OV_MSB:0];
    end else begin
      cfg_r <= cfg_nxt;
      hot_r <= hot_nxt;
      warn_r <= warn_nxt;
      hdr_r <= hdr_nxt;
      if (wr_therm) begin
        tmon_r <= req.data[`BIT_TMON];
        ov_target_r <= req.data[`OV_MSB:0];
      end
    end
  end

  // ==========================================================
  // Self-calibration: step the code until the comparator trips
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cal_st_r <= CAL_IDLE;
      cal_done_r <= 1'b0;
      cal_code_r <= 4'h0;
      cal_cnt_r <= 9'h000;
      cal_result_r <= THERM_RST[`OV_MSB:0];
    end else if (cal_start) begin
      cal_st_r <= CAL_SETTLE;
      cal_done_r <= 1'b0;
      cal_code_r <= 4'h0;
      cal_cnt_r <= 9'h000;
    end else if (cal_abort) begin
      cal_st_r <= CAL_IDLE;
    end else begin
      unique case (cal_st_r)
        CAL_IDLE: begin
        end
        CAL_SETTLE: begin
          cal_cnt_r <= cal_cnt_r + 9'h001;
          if (cal_cnt_r == SETTLE_LAST) begin
            cal_st_r <= CAL_CHECK;
          end
        end
        CAL_CHECK: begin
          cal_cnt_r <= 9'h000;
          if (cal_cmp_s || cal_code_r == `CAL_CODE_MAX) begin
            cal_st_r <= CAL_IDLE;
            cal_done_r <= 1'b1;
            cal_result_r <= cal_code_r;
          end else begin
            cal_st_r <= CAL_SETTLE;
            cal_code_r <= cal_code_r + 4'h1;
          end
        end
        default: begin
          cal_st_r <= CAL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data and outputs
  wire [7:0] rd_cfg = {cal_done_r, cfg_r.psm, strobe_s, cfg_r.gpio_val,
                       cfg_r.pin_type, cfg_r.led_en};
  wire [7:0] rd_tv = {tmon_r, hot_r, warn_r, hdr_r, cal_result_r};
  wire sel_cfg = req.addr == `REG_CAL_CFG_ADDR;
  wire sel_tv = req.addr == `REG_THERM_VOUT_ADDR;
  assign rd_data = sel_cfg ? rd_cfg : (sel_tv ? rd_tv : 8'h00);
  assign cal_active_out = cal_st_r != CAL_IDLE;
  assign power_save_enable_out = cfg_r.psm;
  assign channel_three_enable_out = cfg_r.led_en[2];
  assign channel_two_enable_out = cfg_r.led_en[1];
  assign channel_one_enable_out = cfg_r.led_en[0];
  assign gpio_out = cfg_r.pin_type ? 1'b0 : cfg_r.gpio_val;
  assign gpio_oe_out = cfg_r.dir & (~cfg_r.pin_type | ~cfg_r.gpio_val);
  assign temp_monitor_enable_out = tmon_r;
  assign excess_temp_flag_out = hot_r;
  assign output_voltage_code_out = cal_active_out ? cal_code_r : ov_target_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_cfg_write;
    wr_cfg;
  endsequence
  sequence s_cal_run;
    cal_start ##1 cal_active_out;
  endsequence

  a_cal_start_run: assert property (s_cfg_write ##0 req.data[`BIT_CAL] |=>
    (cal_active_out && !cal_done_r && output_voltage_code_out == 4'h0))
    else $error("calibration did not start");
  a_cal_done_drop: assert property ($fell(cal_done_r) |-> $past(cal_start))
    else $error("calibration done fell without a start");
  a_cal_stop: assert property (cal_abort |=> !cal_active_out)
    else $error("calibration not stopped");
  a_psm_follow: assert property (s_cfg_write |=>
    power_save_enable_out == $past(req.data[`BIT_PSM]))
    else $error("power save bit not taken");
  a_strobe_read: assert property (second_strobe_input_in |-> ##2 rd_cfg[`BIT_DIR])
    else $error("strobe level not visible in read");
  a_gpio_track: assert property (!cfg_r.dir && !wr_cfg |=>
    cfg_r.gpio_val == $past(gpio_s))
    else $error("input pin level not held");
  a_gpio_input_off: assert property (!cfg_r.dir |-> !gpio_oe_out)
    else $error("pin driven while input");
  a_led_enable: assert property (s_cfg_write |=>
    {channel_three_enable_out, channel_two_enable_out, channel_one_enable_out}
      == $past(req.data[2:0]))
    else $error("channel enables not taken");
  a_hot_sticky: assert property (hot_r && !hot_clear |=> hot_r)
    else $error("excess temperature flag lost");
  a_hot_set: assert property (hot_set |=> hot_r [*2] or (hot_r ##1 !hot_r))
    else $error("excess temperature flag not set");
  a_warn_read_clear: assert property (rd_therm && !warn_set |=> !warn_r)
    else $error("warning flag not cleared by read");
  a_hdr_hold: assert property (!flash_end_in |=> $stable(hdr_r))
    else $error("headroom changed outside strobe end");
  a_hdr_update: assert property (flash_end_in |=> hdr_r == $past(hdr_ok_s))
    else $error("headroom not updated at strobe end");
  a_cal_result: assert property ($rose(cal_done_r) |-> rd_tv[3:0] == $past(cal_code_r))
    else $error("calibration result not readable");
  a_ov_write: assert property (wr_therm && !cal_active_out && !cal_start |=>
    output_voltage_code_out == $past(req.data[3:0]))
    else $error("target code not applied");
  a_cal_seq: assert property (s_cal_run |-> ##[1:600] (cal_start || !cal_active_out ||
    output_voltage_code_out != 4'h0))
    else $error("calibration sequence broken");

  // ==========================================================
  // Flag, pin and decode checks
  a_hot_clear: assert property (hot_clear && !hot_set |=> !hot_r)
    else $error("excess temperature flag not cleared");
  a_warn_set: assert property (warn_set |=> warn_r)
    else $error("warning flag not set");
  a_flags_masked: assert property (!tmon_r && !hot_r && !warn_r |=> !hot_r && !warn_r)
    else $error("flag set while monitoring off");
  a_done_idle: assert property (cal_done_r |-> !cal_active_out)
    else $error("calibration done while running");
  a_type_follow: assert property (s_cfg_write |=>
    cfg_r.pin_type == $past(req.data[`BIT_TYPE]))
    else $error("output stage bit not taken");
  a_gpio_drive: assert property (cfg_r.dir && !cfg_r.pin_type |->
    gpio_oe_out && gpio_out == cfg_r.gpio_val)
    else $error("push-pull pin not driven");
  a_tmon_write: assert property (wr_therm |=>
    temp_monitor_enable_out == $past(req.data[`BIT_TMON]))
    else $error("monitor enable not taken");
  a_unmapped_zero: assert property (!sel_cfg && !sel_tv |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule : flash_led_config_status_regs
`default_nettype wire

//--- testbench/i2c_host_model.sv
`default_nettype none
// ====================================
// Serial bus host, open drain on SDA, SCL driven high and low
module i2c_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick();
    repeat (6) @(negedge clk_in);
  endtask : tick
  task automatic start_cond();
    sda_low_out = 1'b0;
    tick();
    scl_out = 1'b1;
    tick();
    sda_low_out = 1'b1;
    tick();
    scl_out = 1'b0;
    tick();
  endtask : start_cond
  task automatic stop_cond();
    sda_low_out = 1'b1;
    tick();
    scl_out = 1'b1;
    tick();
    sda_low_out = 1'b0;
    tick();
  endtask : stop_cond
  // Data set while clock low, sampled in the high phase
  task automatic bit_slot(input logic drive_low, output logic seen);
    sda_low_out = drive_low;
    tick();
    scl_out = 1'b1;
    tick();
    seen = sda_in;
    scl_out = 1'b0;
    tick();
  endtask : bit_slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(~b[i], seen);
    end
    bit_slot(1'b0, seen);
    ack = ~seen;
  endtask : send_byte
  task automatic recv_byte(input logic more, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b0, seen);
      b[i] = seen;
    end
    bit_slot(more, seen);
  endtask : recv_byte
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
                           input logic [7:0] d, output logic ack);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, ack);
    send_byte(sub, a);
    send_byte(d, a);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] sub,
                          output logic [7:0] d);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, a);
    send_byte(sub, a);
    start_cond();
    send_byte({dev, 1'b1}, a);
    recv_byte(1'b0, d);
    stop_cond();
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

//--- testbench/tb.sv
`include "flash_led_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_led_pkg::*;
  localparam logic [6:0] DEV = 7'h5a; // Arbitrary value
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic strobe, gpio_ext, hot, warn, hdr, flash_end;
  logic [3:0] cal_target;
  logic [31:0] rnd;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  wire logic scl, sda_low, sda_line, gpio_pin, cmp;
  logic sda_out, sda_oe_out, gpio_out, gpio_oe_out, pse, ch1, ch2, ch3;
  logic tmon, hotf, cal_act;
  logic [3:0] ov;
  assign sda_line = ~(sda_low | (sda_oe_out & ~sda_out));
  assign gpio_pin = gpio_oe_out ? gpio_out : gpio_ext;
  assign cmp = cal_act & (ov >= cal_target);
  always #12.5 clk_in = ~clk_in;
  i2c_host_model host (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_low_out(sda_low));
  flash_led_config_status_regs #(.DEV_ADDR(DEV)) uut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .second_strobe_input_in(strobe), .gpio_in(gpio_pin),
    .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out), .temp_hot_cmp_in(hot),
    .temp_warn_cmp_in(warn), .cal_compare_in(cmp), .headroom_ok_in(hdr),
    .flash_end_in(flash_end), .power_save_enable_out(pse),
    .channel_one_enable_out(ch1), .channel_two_enable_out(ch2),
    .channel_three_enable_out(ch3), .temp_monitor_enable_out(tmon),
    .excess_temp_flag_out(hotf), .cal_active_out(cal_act),
    .output_voltage_code_out(ov));
  // ====================================
  // Checking helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] cfg_read(input logic [7:0] w, input logic done,
                                          input logic strb, input logic pin);
    return {done, w[6], strb, w[5] ? w[4] : pin, w[3:0]};
  endfunction : cfg_read
  task automatic check_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (exp !== got) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_reg
  task automatic check_pin(input string what, input logic exp, input logic got);
    checked++;
    if (exp !== got) begin
      fails++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : check_pin
  task automatic conclude();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic a;
    host.write_reg(DEV, sub, d, a);
    check_pin("address ack", 1'b1, a);
    repeat (4) @(negedge clk_in);
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    repeat (4) @(negedge clk_in);
    s = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : pulse
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end
  // ====================================
  // Main sequence
  initial begin
    logic [7:0] d, w;
    logic a;
    strobe = 1'b1;
    gpio_ext = 1'b0;
    hot = 1'b0;
    warn = 1'b0;
    hdr = 1'b0;
    flash_end = 1'b0;
    cal_target = 4'h3;
    rnd = 32'h43fe_339a;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check_pin("power_save", 1'b1, pse);
    check_reg("channels", 8'h02, {5'h00, ch3, ch2, ch1});
    check_pin("gpio_oe", 1'b1, gpio_oe_out);
    host.read_reg(DEV, `REG_CAL_CFG_ADDR, d);
    check_reg("cfg reset", `CAL_CFG_RESET, d);
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("therm reset", `THERM_VOUT_RESET, d);
    host.read_reg(DEV, 8'h07, d);
    check_reg("unmapped", 8'h00, d);
    host.write_reg(7'h11, `REG_CAL_CFG_ADDR, 8'h00, a);
    check_pin("foreign ack", 1'b0, a);
    check_pin("power_save kept", 1'b1, pse);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      w = (i == 0) ? 8'h7f : (i == 1) ? 8'h00 : (rnd[7:0] & 8'h7f);
      strobe = rnd[8];
      gpio_ext = rnd[9];
      wr(`REG_CAL_CFG_ADDR, w);
      check_pin("power_save", w[6], pse);
      check_reg("channels", {5'h00, w[2:0]}, {5'h00, ch3, ch2, ch1});
      check_pin("gpio_oe", w[5] & (~w[3] | ~w[4]), gpio_oe_out);
      if (w[5]) begin
        check_pin("gpio_out", w[4] & ~w[3], gpio_out);
      end
      host.read_reg(DEV, `REG_CAL_CFG_ADDR, d);
      check_reg("cfg read", cfg_read(w, 1'b0, strobe, gpio_ext), d);
    end
    for (int c = 0; c < 16; c++) begin
      wr(`REG_THERM_VOUT_ADDR, {4'h0, c[3:0]});
      check_reg("ov code", {4'h0, c[3:0]}, {4'h0, ov});
    end
    wr(`REG_THERM_VOUT_ADDR, 8'h85);
    check_pin("temp_mon", 1'b1, tmon);
    pulse(warn);
    pulse(hot);
    check_pin("hot flag", 1'b1, hotf);
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("therm flags", 8'he9, d);
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("warn cleared", 8'hc9, d);
    wr(`REG_THERM_VOUT_ADDR, 8'hc5);
    check_pin("hot kept", 1'b1, hotf);
    wr(`REG_THERM_VOUT_ADDR, 8'h85);
    check_pin("hot cleared", 1'b0, hotf);
    wr(`REG_THERM_VOUT_ADDR, 8'h05);
    pulse(hot);
    check_pin("hot masked", 1'b0, hotf);
    hdr = 1'b1;
    pulse(flash_end);
    hdr = 1'b0;
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("headroom high", 8'h19, d);
    pulse(flash_end);
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("headroom low", 8'h09, d);
    wr(`REG_CAL_CFG_ADDR, 8'hc2);
    check_pin("cal running", 1'b1, cal_act);
    host.read_reg(DEV, `REG_CAL_CFG_ADDR, d);
    check_reg("cal busy", cfg_read(8'h42, 1'b0, strobe, gpio_ext), d);
    for (int k = 0; k < 8000 && cal_act; k++) begin
      @(negedge clk_in);
    end
    check_pin("cal ended", 1'b0, cal_act);
    host.read_reg(DEV, `REG_CAL_CFG_ADDR, d);
    check_reg("cal done", cfg_read(8'h42, 1'b1, strobe, gpio_ext), d);
    host.read_reg(DEV, `REG_THERM_VOUT_ADDR, d);
    check_reg("cal result", {4'h0, cal_target}, d);
    wr(`REG_CAL_CFG_ADDR, 8'hc2);
    wr(`REG_CAL_CFG_ADDR, 8'h42);
    check_pin("cal aborted", 1'b0, cal_act);
    host.read_reg(DEV, `REG_CAL_CFG_ADDR, d);
    check_reg("restart cleared", cfg_read(8'h42, 1'b0, strobe, gpio_ext), d);
    conclude();
  end
endmodule : tb
`default_nettype wire
